// file: rtl/dram_ctrl_pkg.sv
// Constants for the page-mode dynamic RAM controller
package dram_ctrl_pkg;
   localparam int ADDR_W = 7;
   localparam int ROWS = 128;
   localparam int CLK_MHZ = 50;
   localparam int REFRESH_MS = 2;
   localparam int REFRESH_CYC = REFRESH_MS * 1000 * CLK_MHZ;
   localparam int REFRESH_GAP = REFRESH_CYC / ROWS;
   localparam int WARMUP_CYCLES = 8;
   localparam int PHASE_CYC = 2;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_RAS  = 3'b001,
      S_COL  = 3'b011,
      S_CAS  = 3'b010,
      S_PAGE = 3'b110,
      S_PRE  = 3'b111,
      S_REF  = 3'b101
   } state_t;
endpackage

// file: rtl/dram_ctrl.sv
// Page-mode dynamic RAM controller with refresh and power-up sequencing
`timescale 1ns/10ps
`default_nettype none
module dram_ctrl #(
   parameter int DEVS        = 4,
   parameter int DSEL_W      = 2,
   parameter int REFRESH_GAP = dram_ctrl_pkg::REFRESH_GAP
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              supplyFail,
   input  wire logic              reqValid,
   output logic                   reqReady,
   input  wire logic              reqWrite,
   input  wire logic              reqKeepPage,
   input  wire logic [DSEL_W-1:0] reqDev,
   input  wire logic [13:0]       reqAddr,
   input  wire logic              reqData,
   output logic                   rdValid,
   output logic                   rdData,
   output logic                   ready,
   output logic                   rasN,
   output logic [DEVS-1:0]        casN,
   output logic                   writeN,
   output logic [6:0]             memAddr,
   output logic                   memDin,
   input  wire logic              memDout
);
   localparam int GAP_W = $clog2(REFRESH_GAP + 1);
   localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(REFRESH_GAP - 1);
   localparam logic [1:0] PH_LAST = 2'(dram_ctrl_pkg::PHASE_CYC - 1);
   localparam logic [3:0] WARM_N = 4'(dram_ctrl_pkg::WARMUP_CYCLES);

   dram_ctrl_pkg::state_t state_r, state_nxt;
   logic [1:0]       phase_r;
   logic [GAP_W-1:0] gap_r;
   logic             refPend_r;
   logic [6:0]       refRow_r;
   logic [3:0]       warm_r;
   logic [6:0]       openRow_r;
   logic [DSEL_W-1:0] dev_r;
   logic             wr_r;

   wire phaseDone = (phase_r == PH_LAST);
   wire warmDone  = (warm_r == WARM_N);
   wire takeReq   = reqValid && reqReady;
   wire sameRow   = (reqAddr[13:7] == openRow_r);
   wire pageHit   = (state_r == dram_ctrl_pkg::S_PAGE) && takeReq
                    && sameRow;

   function automatic logic [DEVS-1:0] devSel(input logic [DSEL_W-1:0] d);
      devSel = '1;
      devSel[d] = 1'b0;
   endfunction

   assign ready = warmDone;
   assign reqReady = warmDone && !refPend_r && !supplyFail
                     && (state_r == dram_ctrl_pkg::S_IDLE
                         || (state_r == dram_ctrl_pkg::S_PAGE && sameRow));

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dram_ctrl_pkg::S_IDLE: begin
            if (supplyFail) state_nxt = dram_ctrl_pkg::S_IDLE;
            else if (refPend_r || !warmDone) state_nxt = dram_ctrl_pkg::S_REF;
            else if (takeReq) state_nxt = dram_ctrl_pkg::S_RAS;
         end
         dram_ctrl_pkg::S_RAS:
            if (phaseDone) state_nxt = dram_ctrl_pkg::S_COL;
         dram_ctrl_pkg::S_COL:
            state_nxt = dram_ctrl_pkg::S_CAS;
         dram_ctrl_pkg::S_CAS:
            if (phaseDone) state_nxt = dram_ctrl_pkg::S_PAGE;
         dram_ctrl_pkg::S_PAGE: begin
            if (supplyFail || refPend_r) state_nxt = dram_ctrl_pkg::S_PRE;
            else if (pageHit) state_nxt = dram_ctrl_pkg::S_COL;
            else if (reqValid || !reqKeepPage)
               state_nxt = dram_ctrl_pkg::S_PRE;
         end
         dram_ctrl_pkg::S_PRE:
            if (phaseDone) state_nxt = dram_ctrl_pkg::S_IDLE;
         dram_ctrl_pkg::S_REF:
            if (phaseDone) state_nxt = dram_ctrl_pkg::S_PRE;
         default: state_nxt = dram_ctrl_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= dram_ctrl_pkg::S_IDLE;
         phase_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         phase_r <= (state_nxt != state_r) ? 2'h0 : phase_r + 2'h1;
      end
   end

   // Refresh pacing and row counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_r     <= '0;
         refPend_r <= 1'b0;
         refRow_r  <= 7'h00;
         warm_r    <= 4'h0;
      end else begin
         gap_r <= (gap_r == GAP_LAST) ? '0 : gap_r + 1'b1;
         if (state_r == dram_ctrl_pkg::S_REF && phaseDone) begin
            refRow_r <= refRow_r + 7'h01;
            if (!warmDone) warm_r <= warm_r + 4'h1;
         end
         if (gap_r == GAP_LAST) refPend_r <= 1'b1;
         else if (state_r == dram_ctrl_pkg::S_REF && phaseDone)
            refPend_r <= 1'b0;
      end
   end

   // Request capture: row and column halves latched in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         openRow_r <= 7'h00;
         dev_r     <= '0;
         wr_r      <= 1'b0;
         memDin    <= 1'b0;
      end else if (takeReq) begin
         openRow_r <= reqAddr[13:7];
         dev_r     <= reqDev;
         wr_r      <= reqWrite;
         memDin    <= reqData;
      end
   end

   logic [6:0] colAddr_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) colAddr_r <= 7'h00;
      else if (takeReq) colAddr_r <= reqAddr[6:0];
   end

   // Pin drive, all from flip-flops
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rasN    <= 1'b1;
         casN    <= '1;
         writeN  <= 1'b1;
         memAddr <= 7'h00;
         rdValid <= 1'b0;
         rdData  <= 1'b0;
      end else begin
         rdValid <= 1'b0;
         case (state_nxt)
            dram_ctrl_pkg::S_RAS: begin
               rasN    <= 1'b0;
               casN    <= '1;
               memAddr <= (state_r == dram_ctrl_pkg::S_IDLE)
                          ? reqAddr[13:7] : openRow_r;
            end
            dram_ctrl_pkg::S_COL: begin
               casN    <= '1;
               memAddr <= pageHit ? reqAddr[6:0] : colAddr_r;
               writeN  <= pageHit ? !reqWrite : !wr_r;
            end
            dram_ctrl_pkg::S_CAS:
               casN <= devSel(dev_r);
            dram_ctrl_pkg::S_PAGE: begin
               if (state_r == dram_ctrl_pkg::S_CAS) begin
                  casN    <= '1;
                  writeN  <= 1'b1;
                  rdValid <= !wr_r;
                  rdData  <= memDout;
               end
            end
            dram_ctrl_pkg::S_REF: begin
               rasN    <= 1'b0;
               casN    <= '1;
               memAddr <= refRow_r;
            end
            default: begin
               rasN   <= 1'b1;
               casN   <= '1;
               writeN <= 1'b1;
            end
         endcase
      end
   end

   a_refresh_cas_high: assert property (@(posedge clk) disable iff (rst)
      state_r == dram_ctrl_pkg::S_REF |-> casN == '1)
      else $error("column strobe active in refresh");
   a_cas_needs_ras: assert property (@(posedge clk) disable iff (rst)
      casN != '1 |-> !rasN)
      else $error("column strobe without row strobe");
   a_fail_idle: assert property (@(posedge clk) disable iff (rst)
      supplyFail && state_r == dram_ctrl_pkg::S_IDLE |=> rasN && casN == '1)
      else $error("strobes low during supply failure");
   a_warm_gate: assert property (@(posedge clk) disable iff (rst)
      !warmDone |-> !reqReady)
      else $error("request taken before warm-up");
   a_ref_row_step: assert property (@(posedge clk) disable iff (rst)
      state_r == dram_ctrl_pkg::S_REF && phaseDone
      |=> refRow_r == $past(refRow_r) + 7'h01)
      else $error("refresh row not advanced");
   a_pend_served: assert property (@(posedge clk) disable iff (rst)
      $rose(refPend_r) && !supplyFail |-> ##[1:12] state_r
      == dram_ctrl_pkg::S_REF)
      else $error("refresh not served in time");
   a_page_row_hold: assert property (@(posedge clk) disable iff (rst)
      state_r == dram_ctrl_pkg::S_PAGE && state_nxt == dram_ctrl_pkg::S_COL
      |=> !rasN)
      else $error("row strobe released inside page");
   a_one_device: assert property (@(posedge clk) disable iff (rst)
      $onehot0(~casN))
      else $error("more than one column strobe");
endmodule
`default_nettype wire

// file: test/dram_model.sv
// Behavioural model of the dynamic RAM devices
`timescale 1ns/10ps
`default_nettype none
module dram_model #(
   parameter int DEVS = 2
) (
   input  wire logic            rasN,
   input  wire logic [DEVS-1:0] casN,
   input  wire logic            writeN,
   input  wire logic [6:0]      memAddr,
   input  wire logic            memDin,
   output logic                 memDout
);
   logic       mem [DEVS][16384];
   logic [6:0] row;
   logic [6:0] col [DEVS];
   logic       rdOn [DEVS];
   logic       lastOut = 1'b0;
   // Row latched on row strobe fall; any cycle opens it
   always @(negedge rasN) #1 row = memAddr;
   for (genvar d = 0; d < DEVS; d++) begin : g_dev
      initial rdOn[d] = 1'b0;
      always @(negedge casN[d]) begin
         rdOn[d] = !rasN && writeN;
         if (!rasN) begin
            col[d] = memAddr;
            if (!writeN) mem[d][{row, memAddr}] = memDin;
         end
      end
   end
   // Drives inverse of last read bit unless column strobe low in a read
   always @* begin
      memDout = ~lastOut;
      for (int d = 0; d < DEVS; d++) begin
         if (!casN[d] && rdOn[d]) begin
            memDout = mem[d][{row, col[d]}];
            lastOut = memDout;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/tb.sv
// Testbench for the dynamic RAM controller
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic clk = 0, rst = 1, supplyFail = 0, reqValid = 0, reqWrite = 0;
   logic reqKeepPage = 0, reqDev = 0, reqData = 0;
   logic [13:0] reqAddr = 14'h0000;
   logic reqReady, rdValid, rdData, ready, rasN, writeN, memDin, memDout;
   logic [1:0] casN;
   logic [6:0] memAddr, lastRow;
   logic prevRas, watch = 1, rowBad = 0, casBad = 0;
   int bad_count = 0, checks = 0, refs = 0, falls = 0, f;
   dram_ctrl #(.DEVS(2), .DSEL_W(1), .REFRESH_GAP(40)) dram_ctrl_inst (
      .clk(clk), .rst(rst), .supplyFail(supplyFail), .reqValid(reqValid),
      .reqReady(reqReady), .reqWrite(reqWrite), .reqKeepPage(reqKeepPage),
      .reqDev(reqDev), .reqAddr(reqAddr), .reqData(reqData),
      .rdValid(rdValid), .rdData(rdData), .ready(ready), .rasN(rasN),
      .casN(casN), .writeN(writeN), .memAddr(memAddr), .memDin(memDin),
      .memDout(memDout));
   dram_model #(.DEVS(2)) dram_model_inst (.rasN(rasN), .casN(casN),
      .writeN(writeN), .memAddr(memAddr), .memDin(memDin),
      .memDout(memDout));
   always #10 clk = ~clk;
   always @(negedge clk) begin
      if (prevRas && !rasN) begin
         falls++;
         if (watch) begin
            if (refs > 0 && memAddr !== lastRow + 7'h01) rowBad = 1;
            lastRow = memAddr;
            refs++;
         end
      end
      if (watch && casN !== 2'b11) casBad = 1;
      prevRas = rasN;
   end
   task test_done;
      if (bad_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task hang;
      chk(8'h00, 8'h01);
      test_done;
   endtask
   task send(input logic w, k, dv, input logic [13:0] a, input logic d);
      int n;
      n = 0;
      {reqValid, reqWrite, reqKeepPage, reqDev, reqAddr, reqData} =
         {1'b1, w, k, dv, a, d};
      #1;
      while (reqReady !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      if (n == 300) hang;
      @(negedge clk);
      reqValid = 0;
   endtask
   task getrd(input logic e);
      int n;
      n = 0;
      while (rdValid !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (n == 20) hang;
      chk(rdData, e);
      @(negedge clk);
   endtask
   task t_rw;
      send(1, 0, 0, 14'h2A55, 1);
      send(1, 0, 1, 14'h2A55, 0);
      send(1, 0, 0, 14'h3FFF, 1);
      send(1, 0, 0, 14'h3F80, 0);
      send(0, 0, 0, 14'h2A55, 0);
      getrd(1);
      send(0, 0, 1, 14'h2A55, 0);
      getrd(0);
      send(0, 0, 0, 14'h3FFF, 0);
      getrd(1);
   endtask
   task t_page;
      int n;
      n = 0;
      watch = 1;
      f = refs;
      while (refs == f && n < 100) begin
         @(negedge clk);
         n++;
      end
      watch = 0;
      repeat (6) @(negedge clk);
      f = falls;
      send(1, 1, 0, 14'h0A01, 1);
      send(1, 1, 0, 14'h0A02, 0);
      send(0, 1, 0, 14'h0A01, 0);
      getrd(1);
      send(0, 0, 0, 14'h0A02, 0);
      getrd(0);
      chk(8'(falls - f), 1);
   endtask
   task t_ref;
      {watch, refs, rowBad, casBad} = {1'b1, 0, 1'b0, 1'b0};
      repeat (200) @(negedge clk);
      chk(refs >= 4, 1);
      chk(rowBad, 0);
      chk(casBad, 0);
      watch = 0;
   endtask
   task t_fail;
      supplyFail = 1;
      repeat (3) @(negedge clk);
      chk({rasN, casN, reqReady}, 4'hE);
      supplyFail = 0;
   endtask
   initial begin
      int n;
      n = 0;
      repeat (6) @(negedge clk);
      rst = 0;
      while (ready !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n == 2000) hang;
      chk(refs >= 8, 1);
      chk(casBad, 0);
      watch = 0;
      t_rw;
      t_page;
      t_ref;
      t_fail;
      test_done;
   end
endmodule
`default_nettype wire
